// >>> dv/pm_far_side.sv
// Stand-in for the host and the embedded controller facing the block.
// Assumes the bench calls its tasks; strobes change at falling edges only.
`timescale 1ns/100ps
`default_nettype none

module pm_far_side (
   // Clock.
   input  wire logic              clk_sys,
   // Requests toward the block.
   output var pm1_pkg::cfg_req_t  cfg_req,
   output var pm1_pkg::io_req_t   io_req,
   output var pm1_pkg::ec_req_t   ec_req,
   // Answers from the block.
   input  wire logic [7:0]        cfg_rdata,
   input  wire logic              io_hit,
   input  wire logic [7:0]        io_rdata,
   input  wire logic [7:0]        ec_rdata,
   input  wire logic              ec_irq
);
   // All strobes start low.
   initial begin
      cfg_req = '0;
      io_req  = '0;
      ec_req  = '0;
   end

   // Configuration access; released fields are scrambled so stale values never help.
   task automatic cfg_op(input logic w, input logic [7:0] i, d, output logic [7:0] q);
      @(negedge clk_sys);
      cfg_req = '{rd: !w, wr: w, index: i, data: d};
      @(negedge clk_sys);
      q = cfg_rdata;
      cfg_req = '{rd: 1'b0, wr: 1'b0, index: ~i, data: ~d};
   endtask

   // Host access; the hit flag is looked at while the address stands.
   task automatic io_op(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic h, irq);
      @(negedge clk_sys);
      io_req = '{rd: !w, wr: w, addr: a, data: d};
      #1 h = io_hit;
      @(negedge clk_sys);
      q = io_rdata;
      irq = ec_irq;
      io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
   endtask

   // Controller access.
   task automatic ec_op(input logic w, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
      @(negedge clk_sys);
      ec_req = '{rd: !w, wr: w, addr: a, data: d};
      @(negedge clk_sys);
      q = ec_rdata;
      ec_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
   endtask
endmodule // pm_far_side

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the power event block.
// Assumes the stand-in module drives all requests; one clock, async reset.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   localparam logic [15:0] BASE = 16'h0ff8;
   logic                   clk_sys;
   logic                   reset_n;
   pm1_pkg::cfg_req_t      cfg_req;
   pm1_pkg::io_req_t       io_req;
   pm1_pkg::ec_req_t       ec_req;
   logic [7:0]             cfg_rdata, io_rdata, ec_rdata, q, sts, en, ctl, spare;
   logic [7:0]             rnd = 8'h51;
   logic                   io_hit, ec_irq, sci_n, sleep_enable, h, irq;
   logic [2:0]             sleep_type;
   logic [2:0]             offs [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
   logic [7:0]             cfgs [3] = '{8'h30, 8'h60, 8'h61};
   int                     fail_count = 0;
   int                     total_checks = 0;
   int                     cycles = 0;

   // Clock at 250 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   pm1_event_block dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata), .io_req(io_req), .io_hit(io_hit), .io_rdata(io_rdata),
      .ec_req(ec_req), .ec_rdata(ec_rdata), .ec_irq(ec_irq),
      .controller_sci_out_n(sci_n), .sleep_type(sleep_type), .sleep_enable(sleep_enable));

   pm_far_side far (.clk_sys(clk_sys), .cfg_req(cfg_req), .io_req(io_req), .ec_req(ec_req),
      .cfg_rdata(cfg_rdata), .io_hit(io_hit), .io_rdata(io_rdata), .ec_rdata(ec_rdata),
      .ec_irq(ec_irq));

   // Next pseudo-random byte.
   function automatic logic [7:0] next_rnd(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   // Expected SCI pin level from status, enable and control.
   function automatic logic [7:0] exp_sci(input logic [7:0] s, e, c);
      return {7'h0, !((|(s[2:0] & e[2:0])) || (s[3] && c[1]))};
   endfunction

   // Compares and counts.
   task automatic check(input string name, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run.
   task automatic end_sim;
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Short wrappers for the three ports.
   task automatic hio(input logic w, input logic [2:0] o, input logic [7:0] d);
      far.io_op(w, BASE + {13'h0, o}, d, q, h, irq);
   endtask
   task automatic ec(input logic w, input logic [1:0] a, input logic [7:0] d);
      far.ec_op(w, a, d, q);
   endtask
   task automatic cf(input logic w, input logic [7:0] i, d);
      far.cfg_op(w, i, d, q);
   endtask

   // Cuts a hang short.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   // Main sequence.
   initial begin
      reset_n = 1'b0;
      repeat (12) @(negedge clk_sys);
      reset_n = 1'b1;
      check("sci_rst", {7'h0, sci_n}, 8'h01);
      foreach (cfgs[k]) begin
         cf(1'b0, cfgs[k], 8'h00);
         check("cfg_rst", q, 8'h00);
      end
      hio(1'b0, 3'h1, 8'h00);
      check("hit_idle", {7'h0, h}, 8'h00);
      // Window placed at the top of the valid range.
      cf(1'b1, 8'h30, 8'hff);
      cf(1'b1, 8'h60, 8'hff);
      cf(1'b1, 8'h61, 8'hf8);
      cf(1'b0, 8'h30, 8'h00);
      check("activate", q, 8'h01);
      cf(1'b0, 8'h60, 8'h00);
      check("base_hi", q, 8'h0f);
      cf(1'b0, 8'h61, 8'h00);
      check("base_lo", q, 8'hf8);
      // Random status, enable and control traffic from both sides.
      for (int i = 0; i < 24; i++) begin
         rnd = next_rnd(rnd);
         ec(1'b1, 2'h0, rnd);
         sts = rnd & 8'h8f;
         rnd = next_rnd(rnd);
         hio(1'b1, 3'h3, rnd);
         en = rnd & 8'h07;
         check("irq_en", {7'h0, irq}, 8'h01);
         rnd = next_rnd(rnd);
         hio(1'b1, 3'h5, rnd);
         ctl = rnd & 8'h3e;
         check("irq_ctl", {7'h0, irq}, 8'h01);
         rnd = next_rnd(rnd);
         ec(1'b1, 2'h2, rnd);
         ctl[5] = rnd[5];
         ec(1'b1, 2'h1, ~en);
         check("sleep", {4'h0, sleep_enable, sleep_type}, {4'h0, ctl[5], ctl[4:2]});
         check("sci_set", {7'h0, sci_n}, exp_sci(sts, en, ctl));
         rnd = next_rnd(rnd);
         hio(1'b1, 3'h1, rnd);
         sts = sts & ~rnd;
         check("irq_sts", {7'h0, irq}, 8'h01);
         hio(1'b0, 3'h1, 8'h00);
         check("sts_host", q, sts);
         ec(1'b0, 2'h0, 8'h00);
         check("sts_ec", q, sts);
         ec(1'b0, 2'h1, 8'h00);
         check("en_ec", q, en);
         hio(1'b0, 3'h3, 8'h00);
         check("en_host", q, en);
         ec(1'b0, 2'h2, 8'h00);
         check("ctl_ec", q, ctl);
         hio(1'b0, 3'h5, 8'h00);
         check("ctl_host", q, ctl);
         check("sci_clr", {7'h0, sci_n}, exp_sci(sts, en, ctl));
      end
      // Controller set and host clear in one cycle: the controller wins.
      fork
         far.ec_op(1'b1, 2'h0, 8'h0f, spare);
         hio(1'b1, 3'h1, 8'h83);
      join
      check("irq_race", {7'h0, irq}, 8'h01);
      ec(1'b0, 2'h0, 8'h00);
      check("sts_race", q, 8'h0f);
      // Status without enables stays quiet; the controller then raises SCI itself.
      hio(1'b1, 3'h3, 8'h00);
      hio(1'b1, 3'h5, 8'h00);
      ec(1'b1, 2'h0, 8'hff);
      ec(1'b0, 2'h0, 8'h00);
      check("sts_noen", q, 8'h8f);
      check("sci_noen", {7'h0, sci_n}, 8'h01);
      ec(1'b1, 2'h3, 8'h01);
      ec(1'b0, 2'h3, 8'h00);
      check("sci_sts", {7'h0, q[0]}, 8'h01);
      check("sci_direct", {7'h0, sci_n}, 8'h00);
      // Reserved offsets read zero and never interrupt.
      foreach (offs[k]) begin
         hio(1'b1, offs[k], 8'hff);
         check("irq_rsvd", {7'h0, irq}, 8'h00);
         hio(1'b0, offs[k], 8'h00);
         check("hit_rsvd", {7'h0, h}, 8'h01);
         check("rd_rsvd", q, 8'h00);
      end
      // Window edges and deactivation.
      far.io_op(1'b1, 16'h1003, 8'hff, q, h, irq);
      check("hit_above", {7'h0, h}, 8'h00);
      check("irq_miss", {7'h0, irq}, 8'h00);
      far.io_op(1'b0, 16'h0ff7, 8'h00, q, h, irq);
      check("hit_below", {7'h0, h}, 8'h00);
      cf(1'b1, 8'h30, 8'h00);
      hio(1'b0, 3'h1, 8'h00);
      check("hit_off", {7'h0, h}, 8'h00);
      // A second reset mid-run clears status, direct SCI and configuration again.
      ec(1'b1, 2'h0, 8'h8f);
      @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      ec(1'b0, 2'h0, 8'h00);
      check("sts_rst", q, 8'h00);
      check("sci_rst2", {7'h0, sci_n}, 8'h01);
      cf(1'b0, 8'h61, 8'h00);
      check("base_rst", q, 8'h00);
      end_sim();
   end
endmodule // tb_top

`default_nettype wire

// >>> src/pm1_event_block.sv
// Power event register block: configuration, host I/O window and the
// embedded controller's view of status, enable and control registers.
// Assumes all request strobes come from logic on clk_sys.
//
// What this block does
// [RULE_01] Power button status: controller sets/clears; host one clears, zero ignored.
// [RULE_02] Sleep button status behaves exactly like the power button status.
// [RULE_03] Alarm status set by controller, cleared by host one or controller.
// [RULE_04] Three event enables are host writable, controller read only.
// [RULE_05] Override has controller status bit; its enable is control bit 1.
// [RULE_06] Block fills eight consecutive host I/O addresses from a base.
// [RULE_07] Host decode only while activate register bit 0 is one.
// [RULE_08] Base address high byte from index 0x60, low from 0x61.
// [RULE_09] Software places base on eight-byte boundary at or below 0x0FF8.
// [RULE_10] Status bits clear on host one and on reset; zero ignored.
// [RULE_11] Status sets regardless of enable; SCI only while enable set.
// [RULE_12] Each enable sits at the same position as its status bit.
// [RULE_13] Enable positions lacking a status partner are reserved.
// [RULE_14] Enabled events drive the controller SCI output pin.
// [RULE_15] Controller may assert SCI directly through its own status bit.
// [RULE_16] Block provides wake status, sleep type and sleep enable.
// [RULE_17] Status registers first, then enables, then controls.
// [RULE_18] Second status +1, enable +3, control +5; others read zero.
// [RULE_19] Host write to second status, enable or control interrupts controller.
// [RULE_20] Status bits 0..3 events, bit 7 wake, bits 4..6 zero.
// [RULE_21] Activate and base registers reset to zero, block undecoded.

`timescale 1ns/100ps
`default_nettype none

module pm1_event_block (
   // Clock and reset.
   input  wire logic               clk_sys,
   input  wire logic               reset_n,
   // Configuration port.
   input  wire pm1_pkg::cfg_req_t  cfg_req,
   output logic [7:0]              cfg_rdata,
   // Host I/O port.
   input  wire pm1_pkg::io_req_t   io_req,
   output logic                    io_hit,
   output logic [7:0]              io_rdata,
   // Embedded controller port.
   input  wire pm1_pkg::ec_req_t   ec_req,
   output logic [7:0]              ec_rdata,
   output logic                    ec_irq,
   // Power control outputs.
   output logic                    controller_sci_out_n,
   output logic [2:0]              sleep_type,
   output logic                    sleep_enable
);

   // Configuration state.
   logic [7:0]  activate_q, activate_d;
   logic [7:0]  base_high_q, base_high_d;
   logic [7:0]  base_low_q, base_low_d;
   logic [7:0]  cfg_rdata_q, cfg_rdata_d;

   // Event register state.
   logic [7:0]  status_q, status_d;
   logic [7:0]  enable_q, enable_d;
   logic [7:0]  control_q, control_d;
   logic        sci_status_q, sci_status_d;
   logic        sci_n_q, sci_n_d;
   logic        irq_q, irq_d;
   logic [7:0]  io_rdata_q, io_rdata_d;
   logic [7:0]  ec_rdata_q, ec_rdata_d;

   // Decode helpers.
   logic [11:0] base_addr;
   logic [2:0]  off;
   logic        host_wr;
   logic        host_rd;
   logic        ec_wr_status;
   logic [7:0]  ec_set;
   logic [7:0]  host_clr;
   logic        event_sci;

   // Base address is the twelve-bit relocatable window start.
   assign base_addr = {base_high_q[3:0], base_low_q[7:3], 3'h0}; // RULE_08
   assign off       = io_req.addr[2:0];
   // Window hits only while activated and the upper address matches.
   assign io_hit    = activate_q[pm1_pkg::ACTIVATE_BIT] // RULE_07
                    && (io_req.addr[15:3] == {4'h0, base_addr[11:3]}); // RULE_06
   assign host_wr   = io_hit && io_req.wr;
   assign host_rd   = io_hit && io_req.rd;

   // Configuration next values; fixed zero bits are masked on write.
   always_comb begin
      activate_d  = activate_q;
      base_high_d = base_high_q;
      base_low_d  = base_low_q;
      cfg_rdata_d = cfg_rdata_q;
      if (cfg_req.wr) begin
         case (cfg_req.index)
            pm1_pkg::CFG_ACTIVATE:  activate_d  = cfg_req.data & 8'h01;
            pm1_pkg::CFG_BASE_HIGH:
               base_high_d = cfg_req.data & pm1_pkg::BASE_HIGH_MASK; // RULE_08
            pm1_pkg::CFG_BASE_LOW:
               base_low_d = cfg_req.data & pm1_pkg::BASE_LOW_MASK; // RULE_08
            default:                activate_d  = activate_q;
         endcase
      end
      if (cfg_req.rd) begin
         case (cfg_req.index)
            pm1_pkg::CFG_ACTIVATE:  cfg_rdata_d = activate_q;
            pm1_pkg::CFG_BASE_HIGH: cfg_rdata_d = base_high_q;
            pm1_pkg::CFG_BASE_LOW:  cfg_rdata_d = base_low_q;
            default:                cfg_rdata_d = 8'h00;
         endcase
      end
   end

   // Configuration registers start cleared, so nothing decodes.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         activate_q  <= pm1_pkg::CFG_RESET; // RULE_21
         base_high_q <= pm1_pkg::CFG_RESET; // RULE_21
         base_low_q  <= pm1_pkg::CFG_RESET; // RULE_21
         cfg_rdata_q <= 8'h00;
      end else begin
         activate_q  <= activate_d;
         base_high_q <= base_high_d;
         base_low_q  <= base_low_d;
         cfg_rdata_q <= cfg_rdata_d;
      end
   end

   // Controller status write: ones set, zeros clear; host ones clear.
   assign ec_wr_status = ec_req.wr && (ec_req.addr == pm1_pkg::EC_STATUS);
   assign ec_set   = ec_wr_status ? ec_req.data : 8'h00;
   assign host_clr = (host_wr && off == pm1_pkg::OFF_STATUS_2) ? io_req.data : 8'h00;

   // An event is SCI-worthy only when status and its enable are both set.
   assign event_sci = |(status_q[2:0] & enable_q[2:0]) // RULE_11 RULE_12
                    | (status_q[pm1_pkg::OVERRIDE_BIT]
                       & control_q[pm1_pkg::OVR_EN_BIT]); // RULE_05

   // Event register next values.
   always_comb begin
      status_d     = ec_wr_status ? ec_req.data : status_q; // RULE_01 RULE_02 RULE_03
      // A controller set in the same cycle beats a host clear.
      status_d     = (status_d & ~(host_clr & ~ec_set)) // RULE_10
                   & pm1_pkg::STATUS_MASK; // RULE_20
      enable_d     = enable_q;
      control_d    = control_q;
      sci_status_d = sci_status_q;
      irq_d        = 1'b0;
      if (host_wr) begin
         case (off)
            pm1_pkg::OFF_STATUS_2:  irq_d = 1'b1; // RULE_19
            pm1_pkg::OFF_ENABLE_2: begin
               enable_d = io_req.data & pm1_pkg::ENABLE_MASK; // RULE_04 RULE_13
               irq_d    = 1'b1; // RULE_19
            end
            pm1_pkg::OFF_CONTROL_2: begin
               control_d = io_req.data & pm1_pkg::CONTROL_MASK; // RULE_05 RULE_16
               irq_d     = 1'b1; // RULE_19
            end
            default:                irq_d = 1'b0; // RULE_18
         endcase
      end
      // The controller may only touch the sleep enable in the control register.
      if (ec_req.wr && ec_req.addr == pm1_pkg::EC_CONTROL) begin
         control_d[pm1_pkg::SLEEP_ENABLE_BIT] = ec_req.data[pm1_pkg::SLEEP_ENABLE_BIT];
      end
      if (ec_req.wr && ec_req.addr == pm1_pkg::EC_SCI_STATUS) begin
         sci_status_d = ec_req.data[0]; // RULE_15
      end
      sci_n_d = ~(event_sci | sci_status_q); // RULE_14 RULE_15
   end

   // Host read mux: status, enables, controls in that order.
   always_comb begin
      io_rdata_d = io_rdata_q;
      if (host_rd) begin
         case (off)
            pm1_pkg::OFF_STATUS_2:  io_rdata_d = status_q; // RULE_17
            pm1_pkg::OFF_ENABLE_2:  io_rdata_d = enable_q; // RULE_17
            pm1_pkg::OFF_CONTROL_2: io_rdata_d = control_q; // RULE_17
            default:                io_rdata_d = 8'h00; // RULE_18
         endcase
      end
   end

   // Controller read mux.
   always_comb begin
      ec_rdata_d = ec_rdata_q;
      if (ec_req.rd) begin
         case (ec_req.addr)
            pm1_pkg::EC_STATUS:     ec_rdata_d = status_q;
            pm1_pkg::EC_ENABLE:     ec_rdata_d = enable_q;
            pm1_pkg::EC_CONTROL:    ec_rdata_d = control_q;
            default:                ec_rdata_d = {7'h00, sci_status_q};
         endcase
      end
   end

   // Event registers; status clears on reset.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status_q     <= pm1_pkg::PM_RESET; // RULE_10
         enable_q     <= pm1_pkg::PM_RESET;
         control_q    <= pm1_pkg::PM_RESET;
         sci_status_q <= 1'b0;
         sci_n_q      <= 1'b1;
         irq_q        <= 1'b0;
         io_rdata_q   <= 8'h00;
         ec_rdata_q   <= 8'h00;
      end else begin
         status_q     <= status_d;
         enable_q     <= enable_d;
         control_q    <= control_d;
         sci_status_q <= sci_status_d;
         sci_n_q      <= sci_n_d;
         irq_q        <= irq_d;
         io_rdata_q   <= io_rdata_d;
         ec_rdata_q   <= ec_rdata_d;
      end
   end

   // Outputs other than io_hit come straight from flip-flops.
   assign cfg_rdata            = cfg_rdata_q;
   assign io_rdata             = io_rdata_q;
   assign ec_rdata             = ec_rdata_q;
   assign ec_irq               = irq_q;
   assign controller_sci_out_n = sci_n_q;
   assign sleep_type   = control_q[pm1_pkg::SLP_TYPE_LSB +: 3]; // RULE_16
   assign sleep_enable = control_q[pm1_pkg::SLEEP_ENABLE_BIT]; // RULE_16

   // Checks on the register behaviour.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence host_w1c_s;
      host_wr && off == pm1_pkg::OFF_STATUS_2 && !ec_req.wr;
   endsequence

   sequence enabled_event_s;
      (|(status_q[2:0] & enable_q[2:0])) && !sci_status_q;
   endsequence

   status_clear_a: assert property (host_w1c_s |=> // RULE_10
      ((status_q & $past(io_req.data)) == 8'h00))
      else $error("Status bit not cleared by host one.");

   zero_write_keeps_a: assert property (host_w1c_s // RULE_01
      ##0 (status_q[0] && !io_req.data[0]) |=> status_q[0])
      else $error("Host zero write changed status.");

   set_wins_a: assert property ((ec_wr_status && host_wr // RULE_03
      && off == pm1_pkg::OFF_STATUS_2) |=>
      ((status_q & pm1_pkg::STATUS_MASK) == ($past(ec_req.data)
      & pm1_pkg::STATUS_MASK)))
      else $error("Controller set lost to host clear.");

   // Every host write to +1, +3 or +5 raises the controller interrupt next cycle.
   irq_write_a: assert property ((host_wr && (off == pm1_pkg::OFF_STATUS_2 // RULE_19
      || off == pm1_pkg::OFF_ENABLE_2 || off == pm1_pkg::OFF_CONTROL_2)) |=> ec_irq)
      else $error("Controller interrupt not raised on host write.");

   // Without such a write the interrupt stays low, so each write gives one pulse.
   irq_quiet_a: assert property (!(host_wr && (off == pm1_pkg::OFF_STATUS_2 // RULE_19
      || off == pm1_pkg::OFF_ENABLE_2 || off == pm1_pkg::OFF_CONTROL_2)) |=> !ec_irq)
      else $error("Controller interrupt raised without a host write.");

   no_decode_a: assert property (!activate_q[0] |-> !io_hit) // RULE_07
      else $error("Window decoded while inactive.");

   sci_enabled_a: assert property (enabled_event_s |=> // RULE_14
      !controller_sci_out_n)
      else $error("SCI not raised for enabled event.");

   sci_masked_a: assert property ((enable_q == 8'h00 // RULE_11
      && !control_q[1] && !sci_status_q) |=> controller_sci_out_n)
      else $error("SCI raised with all enables clear.");

   reserved_zero_a: assert property ((status_q[6:4] == 3'h0) // RULE_20
      && (enable_q[7:3] == 5'h00))
      else $error("Reserved bits read nonzero.");

   enable_write_a: assert property ((host_wr // RULE_04
      && off == pm1_pkg::OFF_ENABLE_2) |=>
      enable_q == ($past(io_req.data) & 8'h07))
      else $error("Enable write not stored.");

   // The controller cannot alter the event enables.
   ec_enable_ro_a: assert property ((ec_req.wr && ec_req.addr == pm1_pkg::EC_ENABLE // RULE_04
      && !host_wr) |=> (enable_q == $past(enable_q)))
      else $error("Controller write changed an enable.");

   // A set controller SCI status pulls the pin low on the next edge.
   sci_direct_a: assert property (sci_status_q |=> !controller_sci_out_n) // RULE_15
      else $error("Direct SCI status did not drive the pin.");

   // Configuration bits outside activate and the base field stay zero.
   cfg_fixed_a: assert property ((activate_q[7:1] == 7'h00) // RULE_08
      && (base_high_q[7:4] == 4'h0) && (base_low_q[2:0] == 3'h0))
      else $error("Fixed configuration bit is set.");

   // Control bits other than override enable, sleep type and sleep enable stay zero.
   control_rsvd_a: assert property ((control_q[0] == 1'b0) // RULE_05 RULE_16
      && (control_q[7:6] == 2'h0))
      else $error("Reserved control bit is set.");

   // A host write outside the window leaves every event register alone.
   miss_ignored_a: assert property ((io_req.wr && !io_hit && !ec_req.wr) // RULE_06
      |=> (status_q == $past(status_q)) && (enable_q == $past(enable_q))
      && (control_q == $past(control_q)))
      else $error("Host write outside the window changed a register.");

endmodule // pm1_event_block

`default_nettype wire

// >>> src/pm1_pkg.sv
// Package for the power event block: register indices, field positions,
// reset values and the request structs used on the three access ports.
// Assumes one system clock; all requests are single-cycle strobes.
package pm1_pkg;

   // Configuration register indices (activate, base high, base low).
   localparam logic [7:0] CFG_ACTIVATE   = 8'h30;
   localparam logic [7:0] CFG_BASE_HIGH  = 8'h60;
   localparam logic [7:0] CFG_BASE_LOW   = 8'h61;
   localparam int         ACTIVATE_BIT   = 0;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] BASE_HIGH_MASK = 8'h0f;
   localparam logic [7:0] BASE_LOW_MASK  = 8'hf8;

   // Host I/O offsets within the eight-byte window.
   localparam logic [2:0] OFF_STATUS_1   = 3'h0;
   localparam logic [2:0] OFF_STATUS_2   = 3'h1;
   localparam logic [2:0] OFF_ENABLE_1   = 3'h2;
   localparam logic [2:0] OFF_ENABLE_2   = 3'h3;
   localparam logic [2:0] OFF_CONTROL_1  = 3'h4;
   localparam logic [2:0] OFF_CONTROL_2  = 3'h5;

   // Controller-side register indices.
   localparam logic [1:0] EC_STATUS      = 2'h0;
   localparam logic [1:0] EC_ENABLE      = 2'h1;
   localparam logic [1:0] EC_CONTROL     = 2'h2;
   localparam logic [1:0] EC_SCI_STATUS  = 2'h3;

   // Field layout: status bits, enables at matching positions.
   localparam int         POWER_BIT      = 0;
   localparam int         SLEEP_BIT      = 1;
   localparam int         ALARM_BIT      = 2;
   localparam int         OVERRIDE_BIT   = 3;
   localparam int         WAKE_BIT       = 7;
   localparam int         OVR_EN_BIT     = 1;
   localparam int         SLP_TYPE_LSB   = 2;
   localparam int         SLEEP_ENABLE_BIT     = 5;
   localparam logic [7:0] STATUS_MASK    = 8'h8f;
   localparam logic [7:0] ENABLE_MASK    = 8'h07;
   localparam logic [7:0] CONTROL_MASK   = 8'h3e;
   localparam logic [7:0] PM_RESET       = 8'h00;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  index;
      logic [7:0]  data;
   } cfg_req_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } io_req_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [1:0]  addr;
      logic [7:0]  data;
   } ec_req_t;

endpackage
